// ===== pkg/regfile_pkg.sv
package regfile_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_SEL_W = 4;
  localparam int unsigned EXT_ADDR_W = 24;
  localparam int unsigned SPACE_W = 3;
  localparam int unsigned VEC_NUM_W = 8;
  localparam int unsigned VEC_ENTRY_SHIFT = 2;
  localparam int unsigned VEC_TABLE_BYTES = 1024;
  localparam int unsigned VEC_COUNT = 256;

  // Register index numbers on the internal register bus
  localparam logic [3:0] IDX_PC = 4'h0;
  localparam logic [3:0] IDX_SR = 4'h1;
  localparam logic [3:0] IDX_VBR = 4'h2;
  localparam logic [3:0] IDX_SFC = 4'h3;
  localparam logic [3:0] IDX_DFC = 4'h4;
  localparam logic [3:0] IDX_USP = 4'h5;
  localparam logic [3:0] IDX_SSP = 4'h6;

  // APB map, byte addresses
  localparam logic [11:0] OFF_GPR_BASE = 12'h000;
  localparam logic [11:0] OFF_CTRL_BASE = 12'h040;
  localparam logic [11:0] OFF_CTRL_END = 12'h05c;
  localparam logic [11:0] OFF_VEC_ADDR = 12'h060;
  localparam logic [11:0] OFF_STATUS = 12'h064;

  // Status register fields and reset values
  localparam int unsigned SR_S_BIT = 13;
  localparam logic [15:0] SR_WRITE_MASK = 16'ha71f;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } op_size_t;

  typedef enum logic [2:0] {
    SPC_USER_DATA = 3'h1,
    SPC_USER_PROG = 3'h2,
    SPC_SUPV_DATA = 3'h5,
    SPC_SUPV_PROG = 3'h6,
    SPC_CPU = 3'h7
  } space_code_t;

  typedef enum logic [2:0] {
    ACC_PROG = 3'h1,
    ACC_DATA = 3'h2,
    ACC_CPU = 3'h4
  } access_kind_t;
endpackage

// ===== pkg/lane_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lane_if;
  logic [31:0] old_val;
  logic [31:0] new_val;
  regfile_pkg::op_size_t size;
  logic is_addr;
  logic [31:0] merged;
  modport merger (input old_val, input new_val, input size, input is_addr, output merged);
  modport user (output old_val, output new_val, output size, output is_addr, input merged);
endinterface
`default_nettype wire

// ===== core/size_merge.sv
`timescale 1ns/10ps
`default_nettype none
// Merges a sized write into an old register value.
module size_merge (
  lane_if.merger lane
);
  always_comb begin
    if (lane.is_addr) begin
      // Word writes to address registers sign-extend to the full width
      if (lane.size == regfile_pkg::SZ_WORD) begin
        lane.merged = {{16{lane.new_val[15]}}, lane.new_val[15:0]};
      end else begin
        lane.merged = lane.new_val;
      end
    end else begin
      unique case (lane.size)
        regfile_pkg::SZ_BYTE: lane.merged = {lane.old_val[31:8], lane.new_val[7:0]};
        regfile_pkg::SZ_WORD: lane.merged = {lane.old_val[31:16], lane.new_val[15:0]};
        default: lane.merged = lane.new_val;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== core/cpu_register_file.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Eight data registers hold byte to long operands and addresses.
// - Seven address registers plus two stack pointers hold addresses.
// - Address registers take word and long only; data take byte, word, long.
// - Any of sixteen general registers may act as index register.
// - Privilege bit picks user or supervisor level and stack pointer.
// - At user level, supervisor-only registers are withheld.
// - Privileged instructions are refused at user level.
// - Program counter is 32 bits and holds next instruction address.
// - Status register keeps condition codes of the last operation.
// - Vector address is table base plus vector displacement.
// - Source and destination space registers hold 3-bit codes.
// - Spaces split user/supervisor, program/data, plus a CPU space.
// - Three space code outputs name the space of each access.
// - Addresses are 32 bits inside, 24 bits driven outside.
// - Vector table spans 1024 bytes holding 256 vectors.
module cpu_register_file (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gpr_we,
  input wire logic [3:0] gpr_wsel,
  input wire regfile_pkg::op_size_t gpr_wsize,
  input wire logic [31:0] gpr_wdata,
  input wire logic [3:0] rd_sel_a,
  output logic [31:0] rd_data_a,
  input wire logic [3:0] index_sel,
  input wire logic index_long,
  output logic [31:0] index_value,
  input wire logic ccr_we,
  input wire logic [4:0] ccr_wdata,
  output logic [4:0] cond_codes,
  input wire logic pc_we,
  input wire logic [31:0] pc_wdata,
  output logic [31:0] program_counter,
  input wire logic [7:0] vector_num,
  output logic [31:0] vector_addr,
  input wire logic priv_insn,
  output logic priv_violation,
  input wire regfile_pkg::access_kind_t access_kind,
  input wire logic use_src_space,
  input wire logic use_dst_space,
  input wire logic [31:0] bus_addr_int,
  output logic [23:0] bus_addr_ext,
  output logic [2:0] space_code_outputs,
  output logic supervisor_mode
);
  logic [31:0] data_regs_r [8];
  logic [31:0] data_regs_nxt [8];
  logic [31:0] addr_regs_r [7];
  logic [31:0] addr_regs_nxt [7];
  logic [31:0] user_stack_pointer_r, user_stack_pointer_nxt;
  logic [31:0] supervisor_stack_pointer_r, supervisor_stack_pointer_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic [15:0] status_register_r, status_register_nxt;
  logic [31:0] vector_table_base_r, vector_table_base_nxt;
  logic [2:0] source_space_code_reg_r, source_space_code_reg_nxt;
  logic [2:0] destination_space_code_reg_r, destination_space_code_reg_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic [23:0] bus_addr_r, bus_addr_nxt;
  logic [2:0] space_r, space_nxt;
  logic priv_viol_r, priv_viol_nxt;
  logic [31:0] merged;
  logic [31:0] old_val, index_raw;
  logic sup;
  logic apb_wr, apb_rd;
  logic apb_gpr, apb_ctrl;
  logic [3:0] apb_idx;
  lane_if lane ();

  assign sup = status_register_r[regfile_pkg::SR_S_BIT];
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign apb_gpr = paddr < regfile_pkg::OFF_CTRL_BASE && paddr[1:0] == 2'h0;
  assign apb_ctrl = paddr >= regfile_pkg::OFF_CTRL_BASE && paddr <= regfile_pkg::OFF_CTRL_END
    && paddr[1:0] == 2'h0;
  assign apb_idx = paddr[5:2];

  // Shared read of any general register; index 15 follows the active stack pointer
  function automatic logic [31:0] gpr_read(input logic [3:0] sel);
    if (!sel[3]) begin
      gpr_read = data_regs_r[sel[2:0]];
    end else if (sel[2:0] != 3'h7) begin
      gpr_read = addr_regs_r[sel[2:0]];
    end else begin
      gpr_read = sup ? supervisor_stack_pointer_r : user_stack_pointer_r;
    end
  endfunction

  // A process, not assigns: the reads must follow register updates, not only the selects
  always_comb begin
    old_val = gpr_read(gpr_wsel);
    rd_data_a = gpr_read(rd_sel_a);
    index_raw = gpr_read(index_sel);
    index_value = index_long ? index_raw : {{16{index_raw[15]}}, index_raw[15:0]};
  end
  assign lane.old_val = old_val;
  assign lane.new_val = gpr_wdata;
  assign lane.is_addr = gpr_wsel[3];
  // Byte size is not legal on address registers; treat it as word
  assign lane.size = (gpr_wsel[3] && gpr_wsize == regfile_pkg::SZ_BYTE) ?
    regfile_pkg::SZ_WORD : gpr_wsize;
  assign merged = lane.merged;

  size_merge u_merge (
    .lane(lane)
  );

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_regs_nxt[i] = data_regs_r[i];
    end
    for (int i = 0; i < 7; i++) begin
      addr_regs_nxt[i] = addr_regs_r[i];
    end
    user_stack_pointer_nxt = user_stack_pointer_r;
    supervisor_stack_pointer_nxt = supervisor_stack_pointer_r;
    if (gpr_we) begin
      if (!gpr_wsel[3]) begin
        data_regs_nxt[gpr_wsel[2:0]] = merged;
      end else if (gpr_wsel[2:0] != 3'h7) begin
        addr_regs_nxt[gpr_wsel[2:0]] = merged;
      end else if (sup) begin
        supervisor_stack_pointer_nxt = merged;
      end else begin
        user_stack_pointer_nxt = merged;
      end
    end else if (apb_wr && apb_gpr) begin
      if (!apb_idx[3]) begin
        data_regs_nxt[apb_idx[2:0]] = pwdata;
      end else if (apb_idx[2:0] != 3'h7) begin
        addr_regs_nxt[apb_idx[2:0]] = pwdata;
      end else if (sup) begin
        supervisor_stack_pointer_nxt = pwdata;
      end else begin
        user_stack_pointer_nxt = pwdata;
      end
    end
    // Supervisor-only registers reachable from the bus only at supervisor level
    if (!gpr_we && apb_wr && apb_ctrl && sup) begin
      if (apb_idx[2:0] == regfile_pkg::IDX_USP[2:0]) begin
        user_stack_pointer_nxt = pwdata;
      end
      if (apb_idx[2:0] == regfile_pkg::IDX_SSP[2:0]) begin
        supervisor_stack_pointer_nxt = pwdata;
      end
    end
  end

  always_comb begin
    pc_nxt = pc_r;
    status_register_nxt = status_register_r;
    vector_table_base_nxt = vector_table_base_r;
    source_space_code_reg_nxt = source_space_code_reg_r;
    destination_space_code_reg_nxt = destination_space_code_reg_r;
    if (pc_we) begin
      pc_nxt = pc_wdata;
    end
    if (ccr_we) begin
      status_register_nxt[4:0] = ccr_wdata;
    end
    if (apb_wr && apb_ctrl) begin
      unique case (apb_idx[2:0])
        regfile_pkg::IDX_PC[2:0]: pc_nxt = pc_we ? pc_wdata : pwdata;
        regfile_pkg::IDX_SR[2:0]: begin
          // User code may only touch the five condition code bits
          if (sup) begin
            status_register_nxt = pwdata[15:0] & regfile_pkg::SR_WRITE_MASK;
          end else if (!ccr_we) begin
            status_register_nxt[4:0] = pwdata[4:0];
          end
        end
        regfile_pkg::IDX_VBR[2:0]: if (sup) vector_table_base_nxt = pwdata;
        regfile_pkg::IDX_SFC[2:0]: if (sup) source_space_code_reg_nxt = pwdata[2:0];
        regfile_pkg::IDX_DFC[2:0]: if (sup) destination_space_code_reg_nxt = pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (apb_rd && apb_gpr) begin
      prdata_nxt = gpr_read(apb_idx);
    end else if (apb_rd && apb_ctrl) begin
      unique case (apb_idx[2:0])
        regfile_pkg::IDX_PC[2:0]: prdata_nxt = pc_r;
        regfile_pkg::IDX_SR[2:0]: prdata_nxt = sup ? {16'h0000, status_register_r} :
          {27'h0, status_register_r[4:0]};
        regfile_pkg::IDX_VBR[2:0]: prdata_nxt = sup ? vector_table_base_r : 32'h0000_0000;
        regfile_pkg::IDX_SFC[2:0]: prdata_nxt = sup ? {29'h0, source_space_code_reg_r} : 32'h0;
        regfile_pkg::IDX_DFC[2:0]: prdata_nxt = sup ? {29'h0, destination_space_code_reg_r} : 32'h0;
        regfile_pkg::IDX_USP[2:0]: prdata_nxt = sup ? user_stack_pointer_r : 32'h0;
        regfile_pkg::IDX_SSP[2:0]: prdata_nxt = sup ? supervisor_stack_pointer_r : 32'h0;
        default: prdata_nxt = 32'h0000_0000;
      endcase
      pslverr_nxt = !sup && apb_idx[2:0] != regfile_pkg::IDX_PC[2:0]
        && apb_idx[2:0] != regfile_pkg::IDX_SR[2:0];
    end else if (psel && penable && !apb_gpr && !apb_ctrl) begin
      pslverr_nxt = paddr != regfile_pkg::OFF_VEC_ADDR && paddr != regfile_pkg::OFF_STATUS;
      if (!pwrite && paddr == regfile_pkg::OFF_VEC_ADDR) prdata_nxt = vector_addr;
      if (!pwrite && paddr == regfile_pkg::OFF_STATUS) prdata_nxt = {31'h0, sup};
    end else if (psel && penable && pwrite && apb_ctrl && !sup) begin
      pslverr_nxt = apb_idx[2:0] != regfile_pkg::IDX_PC[2:0]
        && apb_idx[2:0] != regfile_pkg::IDX_SR[2:0];
    end
  end

  always_comb begin
    bus_addr_nxt = bus_addr_int[regfile_pkg::EXT_ADDR_W-1:0];
    priv_viol_nxt = priv_insn && !sup;
    if (use_src_space) begin
      space_nxt = source_space_code_reg_r;
    end else if (use_dst_space) begin
      space_nxt = destination_space_code_reg_r;
    end else begin
      unique case (access_kind)
        regfile_pkg::ACC_PROG: space_nxt = sup ? regfile_pkg::SPC_SUPV_PROG :
          regfile_pkg::SPC_USER_PROG;
        regfile_pkg::ACC_DATA: space_nxt = sup ? regfile_pkg::SPC_SUPV_DATA :
          regfile_pkg::SPC_USER_DATA;
        regfile_pkg::ACC_CPU: space_nxt = regfile_pkg::SPC_CPU;
        default: space_nxt = regfile_pkg::SPC_CPU;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) data_regs_r[i] <= 32'h0000_0000;
      for (int i = 0; i < 7; i++) addr_regs_r[i] <= 32'h0000_0000;
      user_stack_pointer_r <= 32'h0000_0000;
      supervisor_stack_pointer_r <= 32'h0000_0000;
      pc_r <= regfile_pkg::PC_RESET;
      status_register_r <= regfile_pkg::SR_RESET;
      vector_table_base_r <= regfile_pkg::VBR_RESET;
      source_space_code_reg_r <= 3'h0;
      destination_space_code_reg_r <= 3'h0;
      bus_addr_r <= 24'h00_0000;
      space_r <= 3'h0;
      priv_viol_r <= 1'b0;
    end else begin
      data_regs_r <= data_regs_nxt;
      addr_regs_r <= addr_regs_nxt;
      user_stack_pointer_r <= user_stack_pointer_nxt;
      supervisor_stack_pointer_r <= supervisor_stack_pointer_nxt;
      pc_r <= pc_nxt;
      status_register_r <= status_register_nxt;
      vector_table_base_r <= vector_table_base_nxt;
      source_space_code_reg_r <= source_space_code_reg_nxt;
      destination_space_code_reg_r <= destination_space_code_reg_nxt;
      bus_addr_r <= bus_addr_nxt;
      space_r <= space_nxt;
      priv_viol_r <= priv_viol_nxt;
    end
  end

  // Zero-wait APB: read data and error are decoded within the access phase itself
  assign pready = 1'b1;
  assign prdata = prdata_nxt;
  assign pslverr = pslverr_nxt;
  assign cond_codes = status_register_r[4:0];
  assign program_counter = pc_r;
  // Vector numbers are scaled by four, so the table can never exceed its span
  assign vector_addr = vector_table_base_r +
    {22'h0, vector_num, 2'h0};
  assign bus_addr_ext = bus_addr_r;
  assign space_code_outputs = space_r;
  assign supervisor_mode = sup;
  assign priv_violation = priv_viol_r;

  property p_space_prog;
    @(posedge pclk) disable iff (!presetn)
      (presetn && !use_src_space && !use_dst_space && access_kind == regfile_pkg::ACC_PROG && sup)
      |=> space_code_outputs == regfile_pkg::SPC_SUPV_PROG;
  endproperty
  a_space_prog: assert property (p_space_prog) else $error("wrong program space code");
  property p_sfc_select;
    @(posedge pclk) disable iff (!presetn)
      use_src_space |=> space_code_outputs == $past(source_space_code_reg_r);
  endproperty
  a_sfc_select: assert property (p_sfc_select) else $error("source space not driven");
  property p_ext_addr;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> bus_addr_ext == $past(bus_addr_int[23:0]);
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("external address mismatch");
  property p_priv;
    @(posedge pclk) disable iff (!presetn)
      (priv_insn && !sup) |=> priv_violation;
  endproperty
  a_priv: assert property (p_priv) else $error("privileged op not refused");
  property p_sup_ok;
    @(posedge pclk) disable iff (!presetn)
      (priv_insn && sup) |=> !priv_violation;
  endproperty
  a_sup_ok: assert property (p_sup_ok) else $error("supervisor op refused");
  property p_pc;
    @(posedge pclk) disable iff (!presetn)
      (pc_we && !(apb_wr && apb_ctrl)) |=> program_counter == $past(pc_wdata);
  endproperty
  a_pc: assert property (p_pc) else $error("pc not loaded");
  property p_ccr;
    @(posedge pclk) disable iff (!presetn)
      ccr_we |=> cond_codes == $past(ccr_wdata);
  endproperty
  a_ccr: assert property (p_ccr) else $error("condition codes not kept");
  property p_vec;
    @(posedge pclk) disable iff (!presetn)
      vector_addr - vector_table_base_r < 32'd1024;
  endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_byte_keep;
    @(posedge pclk) disable iff (!presetn)
      (gpr_we && !gpr_wsel[3] && gpr_wsize == regfile_pkg::SZ_BYTE)
      |=> data_regs_r[$past(gpr_wsel[2:0])][31:8] == $past(old_val[31:8]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("upper data bits changed");
  property p_vbr_user;
    @(posedge pclk) disable iff (!presetn)
      !sup |=> vector_table_base_r == $past(vector_table_base_r);
  endproperty
  a_vbr_user: assert property (p_vbr_user) else $error("vbr changed at user level");
endmodule
`default_nettype wire

// ===== tb/core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the instruction execution and bus control side of the core.
module core_model (
  input wire logic pclk,
  output logic gpr_we,
  output logic [3:0] gpr_wsel,
  output regfile_pkg::op_size_t gpr_wsize,
  output logic [31:0] gpr_wdata,
  output logic [3:0] rd_sel_a,
  output logic [3:0] index_sel,
  output logic index_long,
  output logic ccr_we,
  output logic [4:0] ccr_wdata,
  output logic pc_we,
  output logic [31:0] pc_wdata,
  output logic [7:0] vector_num,
  output logic priv_insn,
  output regfile_pkg::access_kind_t access_kind,
  output logic use_src_space,
  output logic use_dst_space,
  output logic [31:0] bus_addr_int
);
  initial begin
    {gpr_we, gpr_wsel, gpr_wdata, rd_sel_a, index_sel, index_long} = '0;
    {ccr_we, ccr_wdata, pc_we, pc_wdata, vector_num, priv_insn} = '0;
    {use_src_space, use_dst_space, bus_addr_int} = '0;
    gpr_wsize = regfile_pkg::SZ_LONG;
    access_kind = regfile_pkg::ACC_PROG;
  end

  // Write strobe stands for exactly one edge
  task automatic wr_gpr(input logic [3:0] s, input regfile_pkg::op_size_t z,
                        input logic [31:0] d);
    @(posedge pclk);
    gpr_we <= 1'b1;
    gpr_wsel <= s;
    gpr_wsize <= z;
    gpr_wdata <= d;
    @(posedge pclk);
    gpr_we <= 1'b0;
  endtask

  task automatic wr_ctl(input logic [4:0] cc, input logic [31:0] pc);
    @(posedge pclk);
    ccr_we <= 1'b1;
    ccr_wdata <= cc;
    pc_we <= 1'b1;
    pc_wdata <= pc;
    @(posedge pclk);
    ccr_we <= 1'b0;
    pc_we <= 1'b0;
  endtask

  task automatic look(input logic [3:0] rs, input logic [3:0] is, input logic il,
                      input logic [7:0] vn);
    @(posedge pclk);
    rd_sel_a <= rs;
    index_sel <= is;
    index_long <= il;
    vector_num <= vn;
  endtask

  // Inputs are held; the registered outputs settle after the second edge
  task automatic bus(input regfile_pkg::access_kind_t k, input logic s, input logic d,
                     input logic [31:0] a, input logic p);
    @(posedge pclk);
    access_kind <= k;
    use_src_space <= s;
    use_dst_space <= d;
    bus_addr_int <= a;
    priv_insn <= p;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, priv_violation;
  logic supervisor_mode, gpr_we, index_long, ccr_we, pc_we, priv_insn;
  logic use_src_space, use_dst_space;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, gpr_wdata, rd_data_a, index_value, pc_wdata;
  logic [31:0] program_counter, vector_addr, bus_addr_int;
  logic [3:0] gpr_wsel, rd_sel_a, index_sel;
  logic [4:0] ccr_wdata, cond_codes;
  logic [7:0] vector_num;
  logic [23:0] bus_addr_ext;
  logic [2:0] space_code_outputs;
  regfile_pkg::op_size_t gpr_wsize;
  regfile_pkg::access_kind_t access_kind;
  int num_errors = 0;
  int checked = 0;

  cpu_register_file dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpr_we(gpr_we), .gpr_wsel(gpr_wsel), .gpr_wsize(gpr_wsize),
    .gpr_wdata(gpr_wdata), .rd_sel_a(rd_sel_a), .rd_data_a(rd_data_a),
    .index_sel(index_sel), .index_long(index_long), .index_value(index_value),
    .ccr_we(ccr_we), .ccr_wdata(ccr_wdata), .cond_codes(cond_codes), .pc_we(pc_we),
    .pc_wdata(pc_wdata), .program_counter(program_counter), .vector_num(vector_num),
    .vector_addr(vector_addr), .priv_insn(priv_insn), .priv_violation(priv_violation),
    .access_kind(access_kind), .use_src_space(use_src_space),
    .use_dst_space(use_dst_space), .bus_addr_int(bus_addr_int),
    .bus_addr_ext(bus_addr_ext), .space_code_outputs(space_code_outputs),
    .supervisor_mode(supervisor_mode));

  core_model core_u (.pclk(pclk), .gpr_we(gpr_we), .gpr_wsel(gpr_wsel),
    .gpr_wsize(gpr_wsize), .gpr_wdata(gpr_wdata), .rd_sel_a(rd_sel_a),
    .index_sel(index_sel), .index_long(index_long), .ccr_we(ccr_we),
    .ccr_wdata(ccr_wdata), .pc_we(pc_we), .pc_wdata(pc_wdata), .vector_num(vector_num),
    .priv_insn(priv_insn), .access_kind(access_kind), .use_src_space(use_src_space),
    .use_dst_space(use_dst_space), .bus_addr_int(bus_addr_int));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Read data and error are taken at the edge that samples pready high
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    if (!w)
      `CHK("prdata", e, prdata)
    `CHK("pslverr", ee, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic space(input regfile_pkg::access_kind_t k, input logic s, input logic d,
                       input logic p, input logic [2:0] e, input logic pv);
    logic [31:0] a;
    a = {8'hc3, 13'h0abc, 8'h5a, e};
    core_u.bus(k, s, d, a, p);
    @(negedge pclk);
    `CHK("space_code_outputs", e, space_code_outputs)
    `CHK("bus_addr_ext", a[23:0], bus_addr_ext)
    `CHK("priv_violation", pv, priv_violation)
  endtask

  function automatic logic [31:0] fill_val(input int i);
    return 32'h1111_1111 * i + 32'h8000_9000;
  endfunction

  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    $display("ERROR watchdog expired");
    wrap_up();
  end

  initial begin
    logic [31:0] v;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, 12'h044, 0, 32'h0000_2700, 0);
    acc(0, 12'h064, 0, 32'h0000_0001, 0);
    acc(0, 12'h040, 0, 32'h0000_0000, 0);
    `CHK("supervisor_mode", 1'b1, supervisor_mode)
    for (int i = 0; i < 16; i++)
      acc(1, 12'(i * 4), fill_val(i), 0, 0);
    for (int i = 0; i < 16; i++) begin
      v = fill_val(i);
      core_u.look(4'(i), 4'(i), 1'b1, 8'h00);
      @(negedge pclk);
      `CHK("rd_data_a", v, rd_data_a)
      `CHK("index_value", v, index_value)
      core_u.look(4'(i), 4'(i), 1'b0, 8'h00);
      @(negedge pclk);
      `CHK("index_value", {{16{v[15]}}, v[15:0]}, index_value)
    end
    acc(0, 12'h058, 0, fill_val(15), 0);
    core_u.look(4'h3, 4'h0, 1'b1, 8'h00);
    core_u.wr_gpr(4'h3, regfile_pkg::SZ_LONG, 32'h1234_5678);
    core_u.wr_gpr(4'h3, regfile_pkg::SZ_BYTE, 32'haabb_ccdd);
    @(negedge pclk);
    `CHK("rd_data_a", 32'h1234_56dd, rd_data_a)
    core_u.wr_gpr(4'h3, regfile_pkg::SZ_WORD, 32'haabb_ccdd);
    @(negedge pclk);
    `CHK("rd_data_a", 32'h1234_ccdd, rd_data_a)
    acc(0, 12'h00c, 0, 32'h1234_ccdd, 0);
    core_u.look(4'ha, 4'h0, 1'b1, 8'h00);
    core_u.wr_gpr(4'ha, regfile_pkg::SZ_WORD, 32'h0000_8001);
    @(negedge pclk);
    `CHK("rd_data_a", 32'hffff_8001, rd_data_a)
    core_u.wr_gpr(4'ha, regfile_pkg::SZ_BYTE, 32'h1234_7f7f);
    @(negedge pclk);
    `CHK("rd_data_a", 32'h0000_7f7f, rd_data_a)
    core_u.wr_ctl(5'h15, 32'hdead_beef);
    @(negedge pclk);
    `CHK("cond_codes", 5'h15, cond_codes)
    `CHK("program_counter", 32'hdead_beef, program_counter)
    acc(0, 12'h044, 0, 32'h0000_2715, 0);
    acc(0, 12'h040, 0, 32'hdead_beef, 0);
    acc(1, 12'h040, 32'h0000_1000, 0, 0);
    acc(0, 12'h040, 0, 32'h0000_1000, 0);
    acc(1, 12'h048, 32'h0001_0000, 0, 0);
    for (int j = 0; j < 3; j++) begin
      v = 32'h0001_0000 + ((j == 2) ? 32'h3fc : 32'(j * 4));
      core_u.look(4'h0, 4'h0, 1'b1, (j == 2) ? 8'hff : 8'(j));
      @(negedge pclk);
      `CHK("vector_addr", v, vector_addr)
      acc(0, 12'h060, 0, v, 0);
    end
    acc(1, 12'h04c, 32'hffff_fff5, 0, 0);
    acc(0, 12'h04c, 0, 32'h0000_0005, 0);
    acc(1, 12'h050, 32'h0000_0002, 0, 0);
    acc(0, 12'h050, 0, 32'h0000_0002, 0);
    space(regfile_pkg::ACC_PROG, 0, 0, 1, 3'h6, 0);
    space(regfile_pkg::ACC_DATA, 0, 0, 0, 3'h5, 0);
    space(regfile_pkg::ACC_CPU, 0, 0, 0, 3'h7, 0);
    space(regfile_pkg::ACC_PROG, 1, 1, 0, 3'h5, 0);
    space(regfile_pkg::ACC_DATA, 0, 1, 0, 3'h2, 0);
    acc(0, 12'h068, 0, 32'h0000_0000, 1);
    acc(1, 12'h044, 32'h0000_0000, 0, 0);
    @(negedge pclk);
    `CHK("supervisor_mode", 1'b0, supervisor_mode)
    acc(0, 12'h064, 0, 32'h0000_0000, 0);
    core_u.look(4'hf, 4'h0, 1'b1, 8'h00);
    core_u.wr_gpr(4'hf, regfile_pkg::SZ_LONG, 32'h0000_7770);
    @(negedge pclk);
    `CHK("rd_data_a", 32'h0000_7770, rd_data_a)
    acc(0, 12'h03c, 0, 32'h0000_7770, 0);
    acc(0, 12'h048, 0, 32'h0000_0000, 1);
    acc(1, 12'h048, 32'h0000_0004, 0, 1);
    acc(1, 12'h044, 32'hffff_ffff, 0, 0);
    acc(0, 12'h044, 0, 32'h0000_001f, 0);
    `CHK("supervisor_mode", 1'b0, supervisor_mode)
    space(regfile_pkg::ACC_PROG, 0, 0, 1, 3'h2, 1);
    space(regfile_pkg::ACC_DATA, 0, 0, 0, 3'h1, 0);
    // A second reset mid-run must bring back supervisor level and clear the supervisor stack pointer and vector base
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, 12'h044, 0, 32'h0000_2700, 0);
    acc(0, 12'h058, 0, 32'h0000_0000, 0);
    acc(0, 12'h048, 0, 32'h0000_0000, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
